// file: rtl/iefb_defs.svh
`ifndef IEFB_DEFS_SVH
`define IEFB_DEFS_SVH

// Control port address width
`define IEFB_ADDR_W          20
// Number of latched flag registers
`define IEFB_NUM_FLAG_REGS   9

// Latched flag register offsets
`define IEFB_OFS_LOOP        20'h18024
`define IEFB_OFS_FAULT       20'h18028
`define IEFB_OFS_REQUEST     20'h18030
`define IEFB_OFS_PIN         20'h18038
`define IEFB_OFS_LOG         20'h1803c
`define IEFB_OFS_TRACE       20'h18040
`define IEFB_OFS_SERIAL      20'h18048
`define IEFB_OFS_TIMER       20'h18050
`define IEFB_OFS_ALARM       20'h18054
// Live state register offsets
`define IEFB_OFS_CLK_STATE   20'h18090
`define IEFB_OFS_BOOT_STATE  20'h18094
// Suppress bit bank: same layout, shifted up
`define IEFB_MASK_BASE       20'h18110
`define IEFB_MASK_DELTA      20'h00100

// Bank indices of the flag registers
`define IEFB_IDX_LOOP        4'h0
`define IEFB_IDX_FAULT       4'h1
`define IEFB_IDX_REQUEST     4'h2
`define IEFB_IDX_PIN         4'h3
`define IEFB_IDX_LOG         4'h4
`define IEFB_IDX_TRACE       4'h5
`define IEFB_IDX_SERIAL      4'h6
`define IEFB_IDX_TIMER       4'h7
`define IEFB_IDX_ALARM       4'h8

// Field positions
`define IEFB_BIT_REF_LOST    8
`define IEFB_BIT_LOCK_FALL   1
`define IEFB_BIT_LOCK_RISE   0
`define IEFB_BIT_FAULT_LO    16
`define IEFB_BIT_MEMCTL      31
`define IEFB_BIT_REQ_LO      0
`define IEFB_BIT_PIN_LO      16
`define IEFB_BIT_LOG_FULL    16
`define IEFB_BIT_TRACE       3
`define IEFB_BIT_PROF_LO     0
`define IEFB_BIT_SM_STALL    3
`define IEFB_BIT_SM_BLOCK    2
`define IEFB_BIT_SM_DONE     0
`define IEFB_BIT_TIMER_LO    16
`define IEFB_BIT_ALARM_LO    0
`define IEFB_BIT_CLK_ERR     10
`define IEFB_BIT_BOOT        3

// Reset values
`define IEFB_FLAG_RESET      32'h00000000
`define IEFB_MASK_RESET      32'hffffffff

`endif

// file: rtl/iefb_pkg.sv
package iefb_pkg;

    // Raw event sources, all from outside this clock domain
    typedef struct packed {
        logic       ref_lost;     // Loop reference lost level
        logic       lock;         // Loop lock level
        logic [5:0] dsp_fault;    // 5 protection .. 0 nonmaskable
        logic       memctl_err;   // Memory control hardware error
        logic [3:0] dsp_req;      // DSP request lines 3..0
        logic [7:0] pins;         // General pins 8..1
        logic       log_full;     // Event log FIFO full
        logic       trace_err;    // Trace buffer stack error
        logic [1:0] prof_done;    // Profilers 1..0 done
        logic       sm_stall;     // Serial master stalling
        logic       sm_block;     // Serial master blocked
        logic       sm_done;      // Serial master transfer done
        logic [1:0] timer;        // Timers 2..1
        logic [3:0] alarm;        // Alarm channels 4..1
        logic       clk_err;      // System clock shortfall level
        logic       boot_done;    // Boot sequence finished level
    } iefb_src_type;

    // One word per flag register
    typedef logic [8:0][31:0] iefb_bank_type;

    // Decoded control port address
    typedef struct packed {
        logic       hit;          // Flag or suppress register
        logic       is_mask;      // Suppress bank
        logic       is_clk;       // Clock state register
        logic       is_boot;      // Boot state register
        logic [3:0] idx;          // Bank index
    } iefb_dec_type;

endpackage

// file: rtl/iefb_edge_sync.sv
`timescale 1ns/10ps

module iefb_edge_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    logic [W-1:0] meta_reg;   // First stage, read only by second
    logic [W-1:0] sync_reg;   // Second stage, safe level
    logic [W-1:0] prev_reg;   // Level one cycle earlier

    // Two-stage synchroniser then one history stage
    always_ff @(posedge clock) begin
        if (!nrst) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= raw;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Edges from the synchronised level only
    assign level = sync_reg;
    assign rise  = sync_reg & ~prev_reg;
    assign fall  = ~sync_reg & prev_reg;

endmodule

// file: rtl/iefb_top.sv
// Contract
// [R01] Latch reference-lost flag on rising edge
// [R02] Lock flags: bit1 falling, bit0 rising edge
// [R03] Latch six DSP fault flags, rising edges
// [R04] Latch memory-control error flag bit 31
// [R05] Latch four DSP request flags, rising edges
// [R06] Rise and fall flags for eight pins
// [R07] Latch event-log full flag on rising edge
// [R08] Latch trace error and profiler-done flags
// [R09] Latch serial master stall, block, done
// [R10] Latch timer 2 and timer 1 flags
// [R11] Latch four alarm channel flags
// [R12] Clock shortfall status live at bit 10
// [R13] Boot finished status live at bit 3
// [R14] Host waits for boot before control writes
// [R15] Flags sticky, cleared only by writing one
// [R16] Request output ORs all unsuppressed flags
// [R17] Suppress bit per flag, parallel range
// [R18] Status fields show live input levels
// [R19] Edge from synchronised level versus previous
// [R20] Reset clears flags; set beats clear
`include "iefb_defs.svh"
`timescale 1ns/10ps

module iefb_top (
    input  wire logic                     clock,
    input  wire logic                     nrst,
    input  wire iefb_pkg::iefb_src_type   sources,
    input  wire logic                     reg_wr_en,
    input  wire logic                     reg_rd_en,
    input  wire logic [`IEFB_ADDR_W-1:0]  reg_addr,
    input  wire logic [31:0]              reg_wdata,
    output logic      [31:0]              reg_rdata,
    output logic                          reg_rd_valid,
    output logic                          first_request_output
);

    // Synchronised source levels
    iefb_pkg::iefb_src_type src_level;
    // One-cycle rising edge strobes
    iefb_pkg::iefb_src_type src_rise;
    // One-cycle falling edge strobes
    iefb_pkg::iefb_src_type src_fall;

    // Latched flags, one word per register
    iefb_pkg::iefb_bank_type flags_reg;
    // Flags after this cycle's sets and clears
    iefb_pkg::iefb_bank_type flags_next;
    // Per-flag suppress bits
    iefb_pkg::iefb_bank_type mask_reg;
    // Suppress bits after this cycle's write
    iefb_pkg::iefb_bank_type mask_next;
    // Edge strobes placed in register layout
    iefb_pkg::iefb_bank_type set_vec;
    // Bits that hold a flag at all
    iefb_pkg::iefb_bank_type valid_vec;

    // Address decode of the current access
    iefb_pkg::iefb_dec_type  acc_dec;

    // Read data before the output register
    logic [31:0] rdata_next;
    // Request level before the output register
    logic        request_next;

    // Place edge strobes into the register layout.
    // Called with all-ones to find the implemented bits, so the
    // layout lives in one place only.
    function automatic iefb_pkg::iefb_bank_type place_events(
        input iefb_pkg::iefb_src_type r,
        input iefb_pkg::iefb_src_type f
    );
        iefb_pkg::iefb_bank_type b;
        // Nothing set by default
        b = '0;
        // Loop reference lost, rising only
        b[`IEFB_IDX_LOOP][`IEFB_BIT_REF_LOST] = r.ref_lost;       // [R01]

        // Lock lost on falling, lock gained on rising
        b[`IEFB_IDX_LOOP][`IEFB_BIT_LOCK_FALL] = f.lock;          // [R02]
        b[`IEFB_IDX_LOOP][`IEFB_BIT_LOCK_RISE] = r.lock;          // [R02]

        // Six DSP faults, protection at the top
        for (int i = 0; i < 6; i++) begin
            b[`IEFB_IDX_FAULT][`IEFB_BIT_FAULT_LO + i] = r.dsp_fault[i]; // [R03]
        end

        // Memory control hardware error
        b[`IEFB_IDX_REQUEST][`IEFB_BIT_MEMCTL] = r.memctl_err;    // [R04]

        // DSP request lines 3..0
        for (int i = 0; i < 4; i++) begin
            b[`IEFB_IDX_REQUEST][`IEFB_BIT_REQ_LO + i] = r.dsp_req[i]; // [R05]
        end

        // Each pin: rising flag, falling flag just above
        for (int i = 0; i < 8; i++) begin
            b[`IEFB_IDX_PIN][`IEFB_BIT_PIN_LO + 2*i]     = r.pins[i]; // [R06]
            b[`IEFB_IDX_PIN][`IEFB_BIT_PIN_LO + 2*i + 1] = f.pins[i]; // [R06]
        end

        // Event log FIFO full
        b[`IEFB_IDX_LOG][`IEFB_BIT_LOG_FULL] = r.log_full;        // [R07]

        // Trace stack error and two profilers
        b[`IEFB_IDX_TRACE][`IEFB_BIT_TRACE] = r.trace_err;        // [R08]
        for (int i = 0; i < 2; i++) begin
            b[`IEFB_IDX_TRACE][`IEFB_BIT_PROF_LO + i] = r.prof_done[i]; // [R08]
        end

        // Secondary serial master events
        b[`IEFB_IDX_SERIAL][`IEFB_BIT_SM_STALL] = r.sm_stall;     // [R09]
        b[`IEFB_IDX_SERIAL][`IEFB_BIT_SM_BLOCK] = r.sm_block;     // [R09]
        b[`IEFB_IDX_SERIAL][`IEFB_BIT_SM_DONE]  = r.sm_done;      // [R09]

        // Timers 2 and 1
        for (int i = 0; i < 2; i++) begin
            b[`IEFB_IDX_TIMER][`IEFB_BIT_TIMER_LO + i] = r.timer[i]; // [R10]
        end

        // Alarm unit channels 4..1
        for (int i = 0; i < 4; i++) begin
            b[`IEFB_IDX_ALARM][`IEFB_BIT_ALARM_LO + i] = r.alarm[i]; // [R11]
        end

        return b;
    endfunction

    // Decode a control port address.
    // Suppress registers sit a fixed distance above their flags.
    function automatic iefb_pkg::iefb_dec_type decode_addr(
        input logic [`IEFB_ADDR_W-1:0] a
    );
        iefb_pkg::iefb_dec_type   d;
        logic [`IEFB_ADDR_W-1:0]  f;
        // Nothing decoded by default
        d = '0;
        d.is_mask = (a >= `IEFB_MASK_BASE);
        // Fold suppress addresses onto flag offsets
        f = d.is_mask ? (a - `IEFB_MASK_DELTA) : a;
        case (f)
            // Flag registers and their suppress twins
            `IEFB_OFS_LOOP: begin
                d.hit = 1'b1;
                d.idx = `IEFB_IDX_LOOP;
            end

            `IEFB_OFS_FAULT: begin
                d.hit = 1'b1;
                d.idx = `IEFB_IDX_FAULT;
            end

            `IEFB_OFS_REQUEST: begin
                d.hit = 1'b1;
                d.idx = `IEFB_IDX_REQUEST;
            end

            `IEFB_OFS_PIN: begin
                d.hit = 1'b1;
                d.idx = `IEFB_IDX_PIN;
            end

            `IEFB_OFS_LOG: begin
                d.hit = 1'b1;
                d.idx = `IEFB_IDX_LOG;
            end

            `IEFB_OFS_TRACE: begin
                d.hit = 1'b1;
                d.idx = `IEFB_IDX_TRACE;
            end

            `IEFB_OFS_SERIAL: begin
                d.hit = 1'b1;
                d.idx = `IEFB_IDX_SERIAL;
            end

            `IEFB_OFS_TIMER: begin
                d.hit = 1'b1;
                d.idx = `IEFB_IDX_TIMER;
            end

            `IEFB_OFS_ALARM: begin
                d.hit = 1'b1;
                d.idx = `IEFB_IDX_ALARM;
            end

            // Live state words, never in the suppress range
            `IEFB_OFS_CLK_STATE: begin
                d.is_clk = !d.is_mask;
            end
            `IEFB_OFS_BOOT_STATE: begin
                d.is_boot = !d.is_mask;
            end

            // Unmapped: no effect, reads zero
            default: begin
                d.hit = 1'b0;
            end
        endcase

        return d;
    endfunction

    // Every source crosses two flops before edge detection
    // Raw levels are asynchronous to clock
    iefb_edge_sync #(
        .W ($bits(iefb_pkg::iefb_src_type))
    ) u_edge_sync (
        .clock (clock),
        .nrst  (nrst),
        .raw   (sources),
        .level (src_level),
        .rise  (src_rise),
        .fall  (src_fall)
    );

    // Edges compare the synced level with last cycle's
    assign set_vec   = place_events(src_rise, src_fall);      // [R19]
    // Implemented bit positions; others read zero
    assign valid_vec = place_events('1, '1);
    // Shared decode for reads and writes
    assign acc_dec   = decode_addr(reg_addr);

    // Flag next state: write-one clears, edge sets.
    // The set term is ORed last so an edge landing in the
    // same cycle as a clear is never lost.
    always_comb begin
        // Hold by default
        flags_next = flags_reg;
        for (int i = 0; i < `IEFB_NUM_FLAG_REGS; i++) begin
            // Clear only bits written as one
            if (reg_wr_en && acc_dec.hit && !acc_dec.is_mask
                && (acc_dec.idx == 4'(i))) begin
                flags_next[i] = flags_reg[i] & ~reg_wdata;      // [R15]
            end
            // Sticky set, wins over clear
            // Unimplemented bits always read zero
            flags_next[i] = (flags_next[i] | set_vec[i]) & valid_vec[i]; // [R20]
        end
    end

    // Latched flags, cleared on reset
    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int i = 0; i < `IEFB_NUM_FLAG_REGS; i++) begin
                // Every word back to zero
                flags_reg[i] <= `IEFB_FLAG_RESET;               // [R20]
            end
        end else begin
            // Sets and clears land together
            flags_reg <= flags_next;                          // [R15]
        end
    end

    // Suppress bits: plain read-write, unimplemented bits held low
    always_comb begin
        // Hold by default
        mask_next = mask_reg;
        for (int i = 0; i < `IEFB_NUM_FLAG_REGS; i++) begin
            if (reg_wr_en && acc_dec.hit && acc_dec.is_mask
                && (acc_dec.idx == 4'(i))) begin
                // Unimplemented bits stay low
                mask_next[i] = reg_wdata & valid_vec[i];        // [R17]
            end
        end
    end

    // Suppress bits come up set, so nothing requests until
    // software opts in; latching is not affected by them
    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int i = 0; i < `IEFB_NUM_FLAG_REGS; i++) begin
                // All implemented bits suppressed
                mask_reg[i] <= `IEFB_MASK_RESET & valid_vec[i];   // [R17]
            end
        end else begin
            // Host writes only
            mask_reg <= mask_next;
        end
    end

    // Read mux: flags, suppress bits or live levels
    always_comb begin
        rdata_next = 32'h00000000;
        if (acc_dec.hit && acc_dec.is_mask) begin
            // Suppress bank
            // Index stays below nine whenever hit is set
            rdata_next = mask_reg[acc_dec.idx];
        end else if (acc_dec.hit) begin
            // Latched flags, valid even while suppressed
            rdata_next = flags_reg[acc_dec.idx];
        end else if (acc_dec.is_clk) begin
            // Live shortfall level, no latching
            rdata_next[`IEFB_BIT_CLK_ERR] = src_level.clk_err;  // [R12] [R18]
        end else if (acc_dec.is_boot) begin
            // Low while booting, high once idle
            rdata_next[`IEFB_BIT_BOOT] = src_level.boot_done;   // [R13] [R18]
        end else begin
            // Unmapped reads as zero
            rdata_next = 32'h00000000;
        end
    end

    // Registered read answer, one cycle after the strobe
    always_ff @(posedge clock) begin
        if (!nrst) begin
            // Port idle, no answer pending
            reg_rdata    <= 32'h00000000;
            reg_rd_valid <= 1'b0;
        end else begin
            // One answer pulse per strobe
            reg_rd_valid <= reg_rd_en;
            // Hold data between reads
            if (reg_rd_en) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    // OR of every flag whose suppress bit is clear.
    // A flag latched while suppressed requests as soon as
    // its suppress bit is cleared.
    always_comb begin
        // Nothing requests by default
        request_next = 1'b0;
        for (int i = 0; i < `IEFB_NUM_FLAG_REGS; i++) begin
            // Fold in this word's unsuppressed flags
            request_next = request_next | (|(flags_reg[i] & ~mask_reg[i])); // [R16]
        end
    end

    // Request output from a flop; lags the flag by one cycle
    // so the pin never glitches on decode paths
    always_ff @(posedge clock) begin
        if (!nrst) begin
            // Quiet through reset
            first_request_output <= 1'b0;
        end else begin
            // Follows the flags one cycle late
            first_request_output <= request_next;             // [R16]
        end
    end

endmodule

// file: verif/iefb_top_assertions.sv
`include "iefb_defs.svh"
`timescale 1ns/10ps

module iefb_top_chk (
    input wire logic                    clock,
    input wire logic                    nrst,
    input wire iefb_pkg::iefb_src_type  sources,
    input wire logic                    reg_wr_en,
    input wire logic                    reg_rd_en,
    input wire logic [`IEFB_ADDR_W-1:0] reg_addr,
    input wire logic [31:0]             reg_wdata,
    input wire logic [31:0]             reg_rdata,
    input wire logic                    reg_rd_valid,
    input wire logic                    first_request_output
);
    iefb_pkg::iefb_src_type  src_prev_reg;  // Sources one cycle back
    logic [3:0]              src_age_reg;   // Cycles since a source moved
    logic [3:0]              wr_age_reg;    // Cycles since any write
    logic [`IEFB_ADDR_W-1:0] wr_addr_reg;   // Last write address
    logic                    wr_full_reg;   // Last write was all ones

    default clocking chk_cb @(posedge clock); endclocking
    default disable iff (!nrst);

    // Ages restart at reset so nothing just after it counts as quiet
    always_ff @(posedge clock) begin
        if (!nrst) begin
            src_prev_reg <= '0;
            src_age_reg  <= 4'h0;
            wr_age_reg   <= 4'h0;
            wr_addr_reg  <= '0;
            wr_full_reg  <= 1'b0;
        end else begin
            src_prev_reg <= sources;
            src_age_reg  <= (sources != src_prev_reg) ? 4'h0 :
                            (src_age_reg == 4'hf) ? 4'hf : src_age_reg + 4'h1;
            wr_age_reg   <= reg_wr_en ? 4'h0 :
                            (wr_age_reg == 4'hf) ? 4'hf : wr_age_reg + 4'h1;
            // Remember what the last write aimed at
            if (reg_wr_en) begin
                wr_addr_reg <= reg_addr;
                wr_full_reg <= (reg_wdata == 32'hffffffff);
            end
        end
    end

    reset_quiet_a:
        assert property (disable iff (1'b0) !nrst |=> !first_request_output && !reg_rd_valid)
        else $error("Outputs not idle after reset");
    read_answer_a:
        assert property (reg_rd_en |=> reg_rd_valid)
        else $error("Read not answered in next cycle");
    read_hold_a:
        assert property (!reg_rd_en |=> !reg_rd_valid && $stable(reg_rdata))
        else $error("Read data moved without a read");
    // Live levels cross the two-flop synchroniser well within four quiet cycles
    clock_live_a:
        assert property (reg_rd_en && reg_addr == `IEFB_OFS_CLK_STATE && src_age_reg > 4'h3
            |=> reg_rdata == {21'h0, $past(sources.clk_err), 10'h0})
        else $error("Clock state read wrong");
    boot_live_a:
        assert property (reg_rd_en && reg_addr == `IEFB_OFS_BOOT_STATE && src_age_reg > 4'h3
            |=> reg_rdata == {28'h0, $past(sources.boot_done), 3'h0})
        else $error("Boot state read wrong");
    clear_read_a:
        assert property (reg_rd_en && !reg_wr_en && wr_full_reg && reg_addr == wr_addr_reg
            && reg_addr < 20'h18060 && wr_age_reg < 4'h4 && src_age_reg > 4'h7
            |=> reg_rdata == 32'h0)
        else $error("Flags survive a full clear");
    req_rise_a:
        assert property ($rose(first_request_output) |-> src_age_reg < 4'h7 || wr_age_reg < 4'h5)
        else $error("Request rose without cause");
    req_fall_a:
        assert property ($fell(first_request_output) |-> wr_age_reg < 4'h4)
        else $error("Request fell without a write");
endmodule

bind iefb_top iefb_top_chk i_iefb_top_chk (
    .clock(clock), .nrst(nrst), .sources(sources),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .first_request_output(first_request_output)
);

// file: verif/iefb_host.sv
`include "iefb_defs.svh"
`timescale 1ns/10ps

module iefb_host (
    input  wire logic                    clock,
    input  wire logic [31:0]             reg_rdata,
    input  wire logic                    reg_rd_valid,
    output logic                         reg_wr_en,
    output logic                         reg_rd_en,
    output logic [`IEFB_ADDR_W-1:0]      reg_addr,
    output logic [31:0]                  reg_wdata
);
    logic boot_seen = 1'b0;  // Boot finished has been read

    // Port idle from time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = '0;
        reg_wdata = '0;
    end

    // One read: strobe for one edge, then take the answer
    task automatic rd(input logic [19:0] a, output logic [31:0] d);
        int n;
        @(posedge clock);
        #1;
        reg_rd_en = 1'b1;
        reg_addr  = a;
        @(posedge clock);
        #1;
        reg_rd_en = 1'b0;
        reg_addr  = ~a;  // Released address is scrambled
        for (n = 0; n < 4 && reg_rd_valid !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        d = (reg_rd_valid === 1'b1) ? reg_rdata : 'x;
        if (a == `IEFB_OFS_BOOT_STATE && d[3] === 1'b1) boot_seen = 1'b1;
    endtask

    // One write; held back until the boot has finished, for at most 50 boot state reads
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        logic [31:0] s;
        int          n;
        for (n = 0; n < 50 && !boot_seen; n++) rd(`IEFB_OFS_BOOT_STATE, s);
        @(posedge clock);
        #1;
        reg_wr_en = 1'b1;
        reg_addr  = a;
        reg_wdata = d;  // Ones clear flags
        @(posedge clock);
        #1;
        reg_wr_en = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
endmodule

// file: verif/test_iefb_top.sv
`include "iefb_defs.svh"
`timescale 1ns/10ps

module test_iefb_top;
    logic                    clock = 1'b0;    // 125 MHz
    logic                    nrst = 1'b0;     // Held low at start
    iefb_pkg::iefb_src_type  sources = '0;    // Raw event levels
    logic                    reg_wr_en;
    logic                    reg_rd_en;
    logic [`IEFB_ADDR_W-1:0] reg_addr;
    logic [31:0]             reg_wdata;
    logic [31:0]             reg_rdata;
    logic                    reg_rd_valid;
    logic                    first_request_output;
    integer                  seed = 32'h8795;
    int                      miscompares = 0;
    int                      cmp_count = 0;
    int                      cycles = 0;      // Hang guard
    logic [31:0]             exp_flag [9];    // Model flags
    logic [31:0]             exp_mask [9];    // Model suppress bits
    logic [31:0]             impl [9] = '{32'h103, 32'h3f0000, 32'h8000000f, 32'hffff0000,
                                         32'h10000, 32'hb, 32'hd, 32'h30000, 32'hf};
    logic [19:0]             ofs [9] = '{`IEFB_OFS_LOOP, `IEFB_OFS_FAULT, `IEFB_OFS_REQUEST,
                                        `IEFB_OFS_PIN, `IEFB_OFS_LOG, `IEFB_OFS_TRACE,
                                        `IEFB_OFS_SERIAL, `IEFB_OFS_TIMER, `IEFB_OFS_ALARM};

    always #4 clock = ~clock;

    iefb_top i_iefb_top (
        .clock(clock), .nrst(nrst), .sources(sources),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .first_request_output(first_request_output)
    );

    iefb_host i_iefb_host (
        .clock(clock), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata)
    );

    task automatic tally_and_finish();
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Model: flags latch on edges between two source snapshots
    function automatic void apply_edges(iefb_pkg::iefb_src_type n, iefb_pkg::iefb_src_type p);
        iefb_pkg::iefb_src_type r;
        iefb_pkg::iefb_src_type f;
        r = n & ~p;
        f = ~n & p;
        exp_flag[0] |= {23'h0, r.ref_lost, 6'h0, f.lock, r.lock};
        exp_flag[1] |= {10'h0, r.dsp_fault, 16'h0};
        exp_flag[2] |= {r.memctl_err, 27'h0, r.dsp_req};
        for (int i = 0; i < 8; i++) begin
            exp_flag[3][16+2*i] |= r.pins[i];
            exp_flag[3][17+2*i] |= f.pins[i];
        end
        exp_flag[4] |= {15'h0, r.log_full, 16'h0};
        exp_flag[5] |= {28'h0, r.trace_err, 1'b0, r.prof_done};
        exp_flag[6] |= {28'h0, r.sm_stall, r.sm_block, 1'b0, r.sm_done};
        exp_flag[7] |= {14'h0, r.timer, 16'h0};
        exp_flag[8] |= {28'h0, r.alarm};
    endfunction

    // Request is any flag whose suppress bit is clear
    function automatic logic exp_req();
        logic q;
        q = 1'b0;
        for (int i = 0; i < 9; i++) q |= |(exp_flag[i] & ~exp_mask[i]);
        return q;
    endfunction

    // New levels, then time for sync, latch and request
    task automatic set_src(input iefb_pkg::iefb_src_type n);
        @(posedge clock);
        #1;
        apply_edges(n, sources);
        sources = n;
        repeat (6) @(posedge clock);
    endtask

    // Read back every flag, suppress and state register
    task automatic check_all();
        logic [31:0] d;
        for (int i = 0; i < 9; i++) begin
            i_iefb_host.rd(ofs[i], d);
            cmp32(d, exp_flag[i]);
            i_iefb_host.rd(ofs[i] + `IEFB_MASK_DELTA, d);
            cmp32(d, exp_mask[i]);
        end
        i_iefb_host.rd(`IEFB_OFS_CLK_STATE, d);
        cmp32(d, {21'h0, sources.clk_err, 10'h0});
        i_iefb_host.rd(`IEFB_OFS_BOOT_STATE, d);
        cmp32(d, {28'h0, sources.boot_done, 3'h0});
        i_iefb_host.rd(20'h18034, d);
        cmp32(d, 32'h0);
        cmp_bit(first_request_output, exp_req());
    endtask

    // Cut a hang short
    always @(posedge clock) begin
        cycles++;
        if (cycles == 10000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    initial begin
        iefb_pkg::iefb_src_type nxt;
        logic [31:0]            w;
        logic [31:0]            d;
        int                     j;
        for (int i = 0; i < 9; i++) begin
            exp_flag[i] = 32'h0;
            exp_mask[i] = impl[i];
        end
        repeat (12) @(posedge clock);
        #1;
        nrst = 1'b1;
        check_all();
        // Random levels, then clear, suppress and a read-only write
        for (int k = 0; k < 40; k++) begin
            nxt = 36'({$random(seed), $random(seed)});
            nxt.boot_done = 1'b1;
            set_src(nxt);
            check_all();
            j = {$random(seed)} % 9;
            w = (k % 4 == 0) ? 32'hffffffff : $random(seed);
            i_iefb_host.wr(ofs[j], w);
            exp_flag[j] &= ~w;
            i_iefb_host.rd(ofs[j], d);
            cmp32(d, exp_flag[j]);
            w = $random(seed);
            i_iefb_host.wr(ofs[j] + `IEFB_MASK_DELTA, w);
            exp_mask[j] = w & impl[j];
            i_iefb_host.wr(`IEFB_OFS_CLK_STATE, 32'hffffffff);
            repeat (3) @(posedge clock);
            #1;
            cmp_bit(first_request_output, exp_req());
        end
        tally_and_finish();
    end
endmodule
